/* File: common/usr_pkg.sv */
// Package: register map, field positions, states and carriers of the serial port block
package usr_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_CTRL_A = 8'h04;
    localparam logic [7:0] ADDR_CTRL_B = 8'h08;
    localparam logic [7:0] ADDR_CTRL_C = 8'h0C;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h10;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h14;
    localparam logic [7:0] ADDR_GIE = 8'h18;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int A_TXC = 6;
    localparam int A_U2X = 1;
    localparam int A_MPCM = 0;
    localparam int B_RXCIE = 7;
    localparam int B_TXCIE = 6;
    localparam int B_UDRIE = 5;
    localparam int B_RXEN = 4;
    localparam int B_TXEN = 3;
    localparam int B_CSZ2 = 2;
    localparam int B_TXB8 = 0;
    localparam int C_STOP2 = 3;
    localparam int C_POL = 0;
    localparam int GIE_BIT = 0;
    // ----------------------------------------
    // Reset values and encodings
    // ----------------------------------------
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_C_RESET = 8'h06;
    localparam logic [1:0] MODE_ASYNC = 2'b00;
    localparam logic [1:0] MODE_SYNC = 2'b01;
    localparam logic [3:0] OS_LAST_NORM = 4'd15;
    localparam logic [3:0] OS_LAST_DBL = 4'd7;
    localparam logic [3:0] OS_MID_NORM = 4'd7;
    localparam logic [3:0] OS_MID_DBL = 4'd3;
    localparam logic [1:0] FIFO_DEPTH = 2'd2;
    // ----------------------------------------
    // States and carriers
    // ----------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} usr_rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PARITY, TX_STOP1,
        TX_STOP2} usr_tx_state_t;
    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic pe;
    } usr_rx_entry_t;
endpackage

/* File: src/usr_usart_regs.sv */
// Serial port data location, control/status registers, transmitter and receiver
`timescale 1ns/1ns
// Summary of operation
// - One data address: write transmits, read receives
// - Short characters: upper bits ignored, read zero
// - Writes dropped while buffer-empty flag clear
// - Enabled idle shifter takes buffer, sends serially
// - Two-deep receive FIFO advances on data reads
// - Receive-done flag tracks unread data, flushed
// - Transmit-done sets at idle end, cleared
// - Buffer-empty flag set when writable, after reset
// - Stop-bit error of head character shown
// - Overrun on full FIFO, held char, start
// - Parity error of head character shown
// - Double speed: oversampling 16 becomes 8
// - Filter drops frames lacking address marking
// - Interrupt needs enable, global enable, flag
// - Receiver owns pin; disable flushes, clears errors
// - Transmitter release waits for idle
// - Mode field: async, sync, two unused codes
// - Parity field: off, reserved, even, odd
// - Size high bit joins two low bits
// - Size codes give 5-8 or 9 bits
// - Stop select sets transmitter stop count
// - Sync polarity chooses change and sample edges
// - Twelve-bit divisor, low write reloads prescaler
module usr_usart_regs
    import usr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    output logic rx_pin_owned,
    output logic tx_pin_o,
    output logic tx_pin_oe,
    output logic xck_o,
    output logic xck_oe,
    input wire logic tx_done_irq_ack,
    output logic rx_done_irq,
    output logic tx_done_irq,
    output logic tx_empty_irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] size_bits(input logic [2:0] code);
        case (code)
            3'b000: size_bits = 4'd5;
            3'b001: size_bits = 4'd6;
            3'b010: size_bits = 4'd7;
            3'b111: size_bits = 4'd9;
            default: size_bits = 4'd8;
        endcase
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic pready_reg, pop_ok_reg, gie_reg, u2x_reg, mpcm_reg, txc_reg, dor_reg;
    logic [7:0] prdata_reg, ctrl_b_reg, ctrl_c_reg, baud_lo_reg;
    logic [3:0] baud_hi_reg;
    logic [11:0] presc_reg;
    logic ph_reg, rx_m_reg, rx_s_reg;
    usr_rx_entry_t fifo_mem [0:1];
    usr_rx_entry_t hold_reg;
    logic hold_v_reg, rd_ptr_reg;
    logic [1:0] cnt_reg;
    usr_rx_state_t rx_st_reg;
    logic [3:0] rx_os_reg, rx_bit_reg;
    logic [8:0] rx_sh_reg;
    logic rx_par_reg;
    usr_tx_state_t tx_st_reg;
    logic [3:0] tx_os_reg, tx_bit_reg;
    logic [8:0] tx_buf_reg, tx_sh_reg;
    logic tx_full_reg, tx_line_reg, tx_en_eff_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire cap = psel & penable & ~pready_reg;
    wire done = psel & penable & pready_reg;
    wire sel_data = (paddr == ADDR_DATA);
    wire sel_a = (paddr == ADDR_CTRL_A);
    wire sel_b = (paddr == ADDR_CTRL_B);
    wire sel_c = (paddr == ADDR_CTRL_C);
    wire sel_blo = (paddr == ADDR_BAUD_LO);
    wire sel_bhi = (paddr == ADDR_BAUD_HI);
    wire sel_gie = (paddr == ADDR_GIE);
    wire mapped = sel_data | sel_a | sel_b | sel_c | sel_blo | sel_bhi | sel_gie;
    wire wr = done & pwrite & mapped;
    wire rx_en = ctrl_b_reg[B_RXEN];
    wire [2:0] size_code = {ctrl_b_reg[B_CSZ2], ctrl_c_reg[2:1]};
    wire [3:0] nbits = size_bits(size_code);
    wire [8:0] mask = 9'h1ff >> (4'd9 - nbits);
    wire [1:0] mode = ctrl_c_reg[7:6];
    wire [1:0] pmode = ctrl_c_reg[5:4];
    wire par_en = pmode[1];
    wire mode_async = (mode == MODE_ASYNC);
    wire mode_sync = (mode == MODE_SYNC);
    usr_rx_entry_t head;
    assign head = fifo_mem[rd_ptr_reg];
    wire rxc = (cnt_reg != 2'd0);
    wire udre = ~tx_full_reg;
    wire [7:0] stat_a = {rxc, txc_reg, udre, head.fe & rxc, dor_reg, head.pe & rxc,
        u2x_reg, mpcm_reg};
    wire [7:0] stat_b = {ctrl_b_reg[7:2], head.data[8], ctrl_b_reg[0]};
    wire [7:0] rdata = sel_data ? (head.data[7:0] & mask[7:0]) :
        sel_a ? stat_a : sel_b ? stat_b : sel_c ? ctrl_c_reg : sel_blo ? baud_lo_reg :
        sel_bhi ? {4'h0, baud_hi_reg} : sel_gie ? {7'h00, gie_reg} : 8'h00;
    // One wait state so that read data always comes from a flip-flop
    assign pready = pready_reg;
    assign pslverr = pready_reg & psel & penable & ~mapped;
    assign prdata = {24'h00_0000, prdata_reg};

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            prdata_reg <= 8'h00;
            pop_ok_reg <= 1'b0;
        end else begin
            pready_reg <= cap;
            if (cap) begin
                prdata_reg <= rdata;
                pop_ok_reg <= rxc;
            end
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_b_reg <= CTRL_B_RESET;
            ctrl_c_reg <= CTRL_C_RESET;
            baud_lo_reg <= 8'h00;
            baud_hi_reg <= 4'h0;
            gie_reg <= 1'b0;
            u2x_reg <= 1'b0;
            mpcm_reg <= 1'b0;
        end else if (wr) begin
            if (sel_a) begin
                u2x_reg <= pwdata[A_U2X];
                mpcm_reg <= pwdata[A_MPCM];
            end
            if (sel_b) begin
                ctrl_b_reg <= {pwdata[7:2], 1'b0, pwdata[B_TXB8]};
            end
            if (sel_c) begin
                ctrl_c_reg <= pwdata[7:0];
            end
            if (sel_blo) begin
                baud_lo_reg <= pwdata[7:0];
            end
            if (sel_bhi) begin
                baud_hi_reg <= pwdata[3:0];
            end
            if (sel_gie) begin
                gie_reg <= pwdata[GIE_BIT];
            end
        end
    end

    // ----------------------------------------
    // Baud prescaler and sync clock
    // ----------------------------------------
    // Reloading on a low-byte write restarts the bit timing; frames in flight get corrupted
    wire blo_wr = wr & sel_blo;
    wire tick = (presc_reg == 12'h000);
    wire [3:0] os_last = (u2x_reg & mode_async) ? OS_LAST_DBL : OS_LAST_NORM;
    wire [3:0] os_mid = (u2x_reg & mode_async) ? OS_MID_DBL : OS_MID_NORM;
    wire pol = ctrl_c_reg[C_POL];
    wire sync_tx_edge = mode_sync & tick & (ph_reg == pol);
    wire sync_rx_edge = mode_sync & tick & (ph_reg != pol);
    assign xck_o = ph_reg;
    assign xck_oe = mode_sync;

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_reg <= 12'h000;
            ph_reg <= 1'b0;
        end else begin
            if (blo_wr) begin
                presc_reg <= {baud_hi_reg, pwdata[7:0]};
            end else if (tick) begin
                presc_reg <= {baud_hi_reg, baud_lo_reg};
            end else begin
                presc_reg <= presc_reg - 12'h001;
            end
            ph_reg <= mode_sync ? (ph_reg ^ tick) : 1'b0;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    // Two flops before the pin is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_m_reg <= 1'b1;
            rx_s_reg <= 1'b1;
        end else begin
            rx_m_reg <= rx_pin;
            rx_s_reg <= rx_m_reg;
        end
    end

    assign rx_pin_owned = rx_en;
    wire [3:0] rx_target = (rx_st_reg == RX_START) ? os_mid : os_last;
    wire rx_samp = mode_sync ? sync_rx_edge :
        (mode_async & tick & (rx_st_reg != RX_IDLE) & (rx_os_reg == rx_target));
    wire start_det = rx_en & (rx_st_reg == RX_IDLE) & ~rx_s_reg &
        (mode_sync ? sync_rx_edge : (mode_async & tick));
    wire rx_end = (rx_st_reg == RX_STOP) & rx_samp;
    wire exp_par = (^(rx_sh_reg & mask)) ^ pmode[0];
    wire frame_type = (nbits == 4'd9) ? rx_sh_reg[8] : rx_s_reg;
    wire rx_keep = ~(mpcm_reg & ~frame_type);
    usr_rx_entry_t rx_new;
    assign rx_new = '{data: rx_sh_reg, fe: ~rx_s_reg,
        pe: par_en & (rx_par_reg != exp_par)};
    wire fifo_push = hold_v_reg & (cnt_reg != FIFO_DEPTH);
    wire fifo_pop = done & ~pwrite & sel_data & pop_ok_reg;
    wire hold_load = rx_end & rx_keep & (~hold_v_reg | fifo_push);
    wire overrun = start_det & (cnt_reg == FIFO_DEPTH) & hold_v_reg;
    wire wr_ptr = rd_ptr_reg ^ cnt_reg[0];

    always_ff @(posedge clk) begin
        if (rst || !rx_en) begin
            rx_st_reg <= RX_IDLE;
            rx_os_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 9'h000;
            rx_par_reg <= 1'b0;
        end else begin
            if (rx_st_reg != RX_IDLE && tick) begin
                rx_os_reg <= rx_samp ? 4'h0 : rx_os_reg + 4'h1;
            end
            case (rx_st_reg)
                RX_IDLE: begin
                    if (start_det) begin
                        rx_os_reg <= 4'h0;
                        rx_bit_reg <= 4'h0;
                        rx_sh_reg <= 9'h000;
                        rx_st_reg <= mode_sync ? RX_DATA : RX_START;
                    end
                end
                RX_START: begin
                    if (rx_samp) begin
                        // A start bit that is gone at mid-bit was a glitch
                        rx_st_reg <= rx_s_reg ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_samp) begin
                        rx_sh_reg[rx_bit_reg] <= rx_s_reg;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == nbits - 4'h1) begin
                            rx_st_reg <= par_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_samp) begin
                        rx_par_reg <= rx_s_reg;
                        rx_st_reg <= RX_STOP;
                    end
                end
                default: begin
                    // Only the first stop bit is checked
                    if (rx_samp) begin
                        rx_st_reg <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !rx_en) begin
            hold_v_reg <= 1'b0;
            hold_reg <= '0;
            cnt_reg <= 2'd0;
            rd_ptr_reg <= 1'b0;
            dor_reg <= 1'b0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end else begin
            if (hold_load) begin
                hold_reg <= rx_new;
                hold_v_reg <= 1'b1;
            end else if (fifo_push) begin
                hold_v_reg <= 1'b0;
            end
            if (fifo_push) begin
                fifo_mem[wr_ptr] <= hold_reg;
            end
            if (fifo_pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
            // A fresh overrun beats the clear of a read in the same cycle
            if (overrun) begin
                dor_reg <= 1'b1;
            end else if (fifo_pop) begin
                dor_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    wire tx_strobe = mode_sync ? sync_tx_edge :
        (mode_async & tick & (tx_os_reg == os_last));
    wire stop2 = ctrl_c_reg[C_STOP2];
    wire tx_finish = tx_strobe &
        (((tx_st_reg == TX_STOP1) & ~stop2) | (tx_st_reg == TX_STOP2));
    wire tx_accept = wr & sel_data & udre;
    wire tx_load = tx_full_reg & tx_en_eff_reg & ((tx_st_reg == TX_IDLE) | tx_finish);
    wire tx_par = (^(tx_sh_reg & mask)) ^ pmode[0];
    wire txc_set = tx_finish & ~tx_full_reg;
    wire txc_clr = (wr & sel_a & pwdata[A_TXC]) | tx_done_irq_ack;
    assign tx_pin_o = tx_en_eff_reg ? tx_line_reg : 1'b1;
    assign tx_pin_oe = tx_en_eff_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buf_reg <= 9'h000;
            tx_full_reg <= 1'b0;
            txc_reg <= 1'b0;
            tx_en_eff_reg <= 1'b0;
            tx_os_reg <= 4'h0;
        end else begin
            if (tx_accept) begin
                tx_buf_reg <= {ctrl_b_reg[B_TXB8], pwdata[7:0]};
                tx_full_reg <= 1'b1;
            end else if (tx_load) begin
                tx_full_reg <= 1'b0;
            end
            if (txc_set) begin
                txc_reg <= 1'b1;
            end else if (txc_clr) begin
                txc_reg <= 1'b0;
            end
            // Release waits until nothing is left to send
            if (ctrl_b_reg[B_TXEN]) begin
                tx_en_eff_reg <= 1'b1;
            end else if (tx_st_reg == TX_IDLE && !tx_full_reg) begin
                tx_en_eff_reg <= 1'b0;
            end
            if (mode_async && tick) begin
                tx_os_reg <= (tx_os_reg == os_last) ? 4'h0 : tx_os_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_reg <= TX_IDLE;
            tx_sh_reg <= 9'h000;
            tx_bit_reg <= 4'h0;
            tx_line_reg <= 1'b1;
        end else begin
            case (tx_st_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg <= tx_buf_reg;
                        tx_st_reg <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    if (tx_strobe) begin
                        tx_line_reg <= 1'b0;
                        tx_st_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_strobe) begin
                        tx_line_reg <= tx_sh_reg[0];
                        tx_bit_reg <= 4'h0;
                        tx_st_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_strobe) begin
                        if (tx_bit_reg == nbits - 4'h1) begin
                            tx_line_reg <= par_en ? tx_par : 1'b1;
                            tx_st_reg <= par_en ? TX_PARITY : TX_STOP1;
                        end else begin
                            tx_line_reg <= tx_sh_reg[tx_bit_reg + 4'h1];
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                end
                TX_PARITY: begin
                    if (tx_strobe) begin
                        tx_line_reg <= 1'b1;
                        tx_st_reg <= TX_STOP1;
                    end
                end
                TX_STOP1: begin
                    if (tx_strobe) begin
                        tx_st_reg <= stop2 ? TX_STOP2 : TX_IDLE;
                    end
                end
                default: begin
                    if (tx_strobe) begin
                        tx_st_reg <= TX_IDLE;
                    end
                end
            endcase
            // Back to back: next start bit follows the last stop bit directly
            if (tx_finish && tx_load) begin
                tx_sh_reg <= tx_buf_reg;
                tx_line_reg <= 1'b0;
                tx_st_reg <= TX_START;
            end
        end
    end

    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    assign rx_done_irq = ctrl_b_reg[B_RXCIE] & gie_reg & rxc;
    assign tx_done_irq = ctrl_b_reg[B_TXCIE] & gie_reg & txc_reg;
    assign tx_empty_irq = ctrl_b_reg[B_UDRIE] & gie_reg & udre;
endmodule

/* File: testbench/usr_chk.sv */
// Checker: port-level relations of the serial port register block
`timescale 1ns/1ns
module usr_chk
    import usr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_pin_owned,
    input wire logic tx_pin_o,
    input wire logic tx_pin_oe,
    input wire logic tx_done_irq_ack,
    input wire logic rx_done_irq,
    input wire logic tx_done_irq,
    input wire logic tx_empty_irq
);
    // ----
    // Shadow of enables, rebuilt from bus writes
    // ----
    logic [7:0] ctrl_b_reg;
    logic gie_reg;
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_b_reg <= CTRL_B_RESET;
            gie_reg <= 1'b0;
        end else if (wr_done && paddr == ADDR_CTRL_B) begin
            ctrl_b_reg <= pwdata[7:0];
        end else if (wr_done && paddr == ADDR_GIE) begin
            gie_reg <= pwdata[GIE_BIT];
        end
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence start_s;
        $fell(tx_pin_o) ##0 tx_pin_oe;
    endsequence
    apb_wait_a: assert property (access_s |=> pready)
        else $error("pready late");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready too long");
    unmapped_err_a: assert property (pslverr |-> pready &&
        (paddr > ADDR_GIE || paddr[1:0] != 2'b00))
        else $error("bad error response");
    rx_irq_gate_a: assert property (rx_done_irq |-> gie_reg && ctrl_b_reg[B_RXCIE])
        else $error("receive irq ungated");
    tx_irq_gate_a: assert property (tx_done_irq |-> gie_reg && ctrl_b_reg[B_TXCIE])
        else $error("transmit irq ungated");
    empty_irq_gate_a: assert property (tx_empty_irq |-> gie_reg && ctrl_b_reg[B_UDRIE])
        else $error("empty irq ungated");
    rx_owner_a: assert property (rx_pin_owned == ctrl_b_reg[B_RXEN])
        else $error("receive pin owner");
    tx_release_a: assert property ($fell(tx_pin_oe) |-> !ctrl_b_reg[B_TXEN])
        else $error("early pin release");
    tx_idle_high_a: assert property (!tx_pin_oe |-> tx_pin_o)
        else $error("released pin low");
    tx_start_a: assert property (start_s |-> ctrl_b_reg[B_TXEN] ##1 !tx_pin_o)
        else $error("bad start bit");
    txc_ack_a: assert property (tx_done_irq_ack |=> !tx_done_irq)
        else $error("transmit irq kept");
endmodule

/* File: testbench/usr_partner.sv */
// Remote serial station: drives the receive line, decodes the transmit line
`timescale 1ns/1ns
module usr_partner #(
    parameter int BT = 16
) (
    input wire logic clk,
    input wire logic tx_pin_o,
    input wire logic tx_pin_oe,
    output logic rx_pin,
    output logic got_v,
    output logic [8:0] got
);
    logic [7:0] b;
    initial begin
        rx_pin = 1'b1;
        got_v = 1'b0;
        got = 9'h000;
    end
    task automatic bit_out(input logic v);
        rx_pin <= v;
        repeat (BT) @(posedge clk);
    endtask
    // Bad frames: flipped parity, or low stop bit without parity
    task automatic send(input logic [8:0] d, input int n, input int par, input logic bad);
        logic p;
        p = ^(d & ((9'h001 << n) - 9'h001)) ^ par[0] ^ bad;
        bit_out(1'b0);
        for (int i = 0; i < n; i++)
            bit_out(d[i]);
        if (par >= 2)
            bit_out(p);
        bit_out(!(bad && par < 2));
        bit_out(1'b1);
        bit_out(1'b1);
    endtask
    // Mid-bit sampling of 8N1 frames; stop bit reported in bit 8
    always begin
        @(posedge clk);
        if (tx_pin_oe === 1'b1 && tx_pin_o === 1'b0) begin
            repeat (BT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BT) @(posedge clk);
                b[i] = tx_pin_o;
            end
            repeat (BT) @(posedge clk);
            got <= {tx_pin_o, b};
            got_v <= 1'b1;
            @(posedge clk);
            got_v <= 1'b0;
        end
    end
endmodule

/* File: testbench/usr_usart_regs_tb.sv */
// Self-checking bench for the serial port register block
`timescale 1ns/1ns
module usr_usart_regs_tb
    import usr_pkg::*;
();
    logic clk, rst, psel, penable, pwrite, pready, pslverr, rx_pin, rx_pin_owned, ack;
    logic tx_pin_o, tx_pin_oe, xck_o, xck_oe, rx_done_irq, tx_done_irq, tx_empty_irq, got_v;
    logic [7:0] paddr;
    logic [8:0] got;
    logic [31:0] pwdata, prdata, rdata, t, m, fl, cc;
    logic [31:0] seed = 32'h0001_52AF;
    logic [64:0] e;
    logic [64:0] exq[$];
    logic [7:0] serq[$];
    int miscompares = 0;
    int total_checks = 0;
    usr_usart_regs dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_pin, .rx_pin_owned, .tx_pin_o, .tx_pin_oe, .xck_o, .xck_oe,
        .tx_done_irq_ack(ack), .rx_done_irq, .tx_done_irq, .tx_empty_irq);
    usr_partner pm (.clk, .tx_pin_o, .tx_pin_oe, .rx_pin, .got_v, .got);
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input logic [32:0] g, input logic [32:0] x);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic [31:0] mk = 32'h0000_00FF, input logic er = 1'b0);
        exq.push_back({er, mk, x});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // A flag that never comes ends the poll after 300 reads, with no check of its own
    task automatic poll(input logic [7:0] a, input int bn);
        repeat (300) begin
            apb(1'b0, a, 32'h0000_0000);
            if (rdata[bn] === 1'b1)
                break;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----
    // Watchers and watchdog
    // ----
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0) begin
            e = exq.pop_front();
            cmp({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
        end
        if (got_v === 1'b1)
            cmp({24'h00_0000, got}, {24'h00_0000, 1'b1, serq.pop_front()});
    end
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        ack <= 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_CTRL_A, 32'h0000_0020);
        rd(ADDR_CTRL_B, {24'h00_0000, CTRL_B_RESET});
        rd(ADDR_CTRL_C, {24'h00_0000, CTRL_C_RESET});
        rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        $display("test reset done");
        apb(1'b1, ADDR_GIE, 32'h0000_0001);
        apb(1'b1, ADDR_CTRL_B, 32'h0000_00E8);
        for (int i = 0; i < 3; i++) begin
            t = xs();
            serq.push_back(t[7:0]);
            apb(1'b1, ADDR_DATA, t);
            if (i == 0)
                poll(ADDR_CTRL_A, 5);
            if (i == 1) begin
                rd(ADDR_CTRL_A, 32'h0000_0000, 32'h0000_0020);
                apb(1'b1, ADDR_DATA, xs());
                poll(ADDR_CTRL_A, A_TXC);
                ack <= 1'b1;
                @(posedge clk);
                ack <= 1'b0;
                rd(ADDR_CTRL_A, 32'h0000_0000, 32'h0000_0040);
            end
        end
        poll(ADDR_CTRL_A, A_TXC);
        apb(1'b1, ADDR_CTRL_A, 32'h0000_0040);
        rd(ADDR_CTRL_A, 32'h0000_0000, 32'h0000_0040);
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0000);
        $display("test transmit done");
        apb(1'b1, ADDR_CTRL_B, 32'h0000_00D0);
        for (int k = 0; k < 5; k++) begin
            cc = (k == 1) ? 32'h00 : (k == 2) ? 32'h26 : (k == 4) ? 32'h36 : 32'h06;
            m = (k == 1) ? 32'h0000_001F : 32'h0000_00FF;
            fl = (k == 2) ? 32'h0000_0004 : (k == 3) ? 32'h0000_0010 : 32'h0000_0000;
            apb(1'b1, ADDR_CTRL_C, cc);
            t = xs();
            pm.send(t[8:0], (k == 1) ? 5 : 8, int'(cc[5:4]), k == 2 || k == 3);
            pm.send(t[16:8], (k == 1) ? 5 : 8, int'(cc[5:4]), 1'b0);
            rd(ADDR_CTRL_A, 32'h80 | fl, 32'h0000_009C);
            rd(ADDR_CTRL_B, 32'h0000_00D0);
            rd(ADDR_DATA, t & m, 32'hFFFF_FFFF);
            rd(ADDR_CTRL_A, 32'h0000_0080, 32'h0000_009C);
            rd(ADDR_DATA, (t >> 8) & m, 32'hFFFF_FFFF);
            rd(ADDR_CTRL_A, 32'h0000_0000, 32'h0000_0080);
        end
        apb(1'b1, ADDR_CTRL_C, 32'h0000_0006);
        repeat (4) begin
            t = xs();
            pm.send(t[8:0], 8, 0, 1'b0);
        end
        rd(ADDR_CTRL_A, 32'h0000_0088, 32'h0000_0088);
        apb(1'b1, ADDR_CTRL_B, 32'h0000_0000);
        rd(ADDR_CTRL_A, 32'h0000_0000, 32'h0000_009C);
        $display("test receive done");
        end_of_test();
    end
endmodule
bind usr_usart_regs usr_chk chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .rx_pin_owned, .tx_pin_o, .tx_pin_oe, .tx_done_irq_ack, .rx_done_irq,
    .tx_done_irq, .tx_empty_irq);
